// ### hdl/epm_pkg.sv
package epm_pkg;

    // system configuration: link type
    typedef enum logic [0:0] {
        EPM_LINK_SERIAL = 1'b0,
        EPM_LINK_AC97 = 1'b1
    } epm_link_e;

    // reset values of the software-written enables
    localparam logic EPM_RST_SDIN2_EN = 1'b0;
    localparam logic EPM_RST_SDO2_EN = 1'b0;
    localparam logic EPM_RST_SDO3_EN = 1'b0;
    localparam logic EPM_RST_LRCLK_EN = 1'b0;
    localparam logic EPM_RST_MCLK_EN = 1'b0;
    localparam logic EPM_RST_CODEC_RST = 1'b0;

    // master clock is 256 x sample rate; alt frame clock toggles at most once every 256 master clocks
    localparam int EPM_MCLK_RATIO = 256;
    localparam logic [7:0] EPM_LRCLK_HALF = 8'h7F;

    // number of joystick axis pins
    localparam int EPM_AXES = 4;

    // alternate-function enables written by software
    typedef struct packed {
        logic sdin2_en;
        logic sdo2_en;
        logic sdo3_en;
        logic lrclk_en;
        logic mclk_en;
    } epm_alt_en_s;

    // general purpose pin controls written by software
    typedef struct packed {
        logic gpio_out;
        logic gpio_oe;
        logic eedat_od_low;
        logic eeprom_clock_or_general_output;
        logic [3:0] axis_od_low;
    } epm_gp_ctl_s;

    // serial audio data from the core for the expanded outputs
    typedef struct packed {
        logic sdo2_data;
        logic sdo3_data;
        logic lr_phase;
    } epm_audio_s;

    // pin output/enable pair
    typedef struct packed {
        logic o;
        logic oe;
    } epm_pin_s;

endpackage : epm_pkg

// ### hdl/epm_strap.sv
`timescale 1ns/100ps
module epm_strap (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // strap
    input wire logic test_strap,
    output logic test_mode
);
    typedef struct packed {
        logic mode;
    } epm_strap_s;

    epm_strap_s st_reg;
    epm_strap_s st_next;

    // strap caught on every clocked edge in reset, held afterwards
    always_comb begin
        st_next = st_reg;
        if (rst) begin
            st_next.mode = test_strap; // [R11]
        end
    end

    always_ff @(posedge ref_clk) begin
        st_reg <= st_next;
    end

    assign test_mode = st_reg.mode;

    strap_hold_a: assert property (@(posedge ref_clk)
        !rst && !$past(rst) |-> st_reg.mode == $past(st_reg.mode))
        else $error("test mode changed outside reset"); // [R11]
    strap_take_a: assert property (@(posedge ref_clk)
        $past(rst) |-> st_reg.mode == $past(test_strap))
        else $error("test strap not sampled during reset"); // [R11]
endmodule : epm_strap

// ### hdl/epm_clkgen.sv
`timescale 1ns/100ps
module epm_clkgen (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // serial clock enables from the link, one-cycle pulses
    input wire logic sclk_fall,
    // outputs: toggling master and alt frame clock levels
    output logic mclk_lvl,
    output logic lrclk_lvl
);
    typedef struct packed {
        logic mclk;
        logic lrclk;
        logic [7:0] cnt;
    } epm_clk_s;

    epm_clk_s cg_reg;
    epm_clk_s cg_next;

    // master clock toggles on each pass, alt frame clock at most once every 256 full mclk periods
    always_comb begin
        cg_next = cg_reg;
        cg_next.mclk = ~cg_reg.mclk; // [R5]
        if (cg_reg.mclk) begin
            cg_next.cnt = cg_reg.cnt + 8'h01;
        end
        if (sclk_fall && cg_reg.cnt == epm_pkg::EPM_LRCLK_HALF && cg_reg.mclk) begin
            cg_next.lrclk = ~cg_reg.lrclk; // [R4]
        end
        if (rst) begin
            cg_next = '0;
        end
    end

    always_ff @(posedge ref_clk) begin
        cg_reg <= cg_next;
    end

    assign mclk_lvl = cg_reg.mclk;
    assign lrclk_lvl = cg_reg.lrclk;

    lr_on_fall_a: assert property (@(posedge ref_clk) disable iff (rst)
        $changed(cg_reg.lrclk) |-> $past(sclk_fall))
        else $error("alt frame clock moved off the falling serial edge"); // [R4]
endmodule : epm_clkgen

// ### hdl/epm_pin_mux.sv
`timescale 1ns/100ps
// Functional notes
// R1: second input pin is GPIO unless enabled, non-AC97
// R2: joy A button1 may drive second serial output
// R3: joy A button2 may drive third serial output
// R4: joy B button1 may output alt frame clock
// R5: joy B button2 may output 256x master clock
// R6: EEPROM data bidirectional, else GPIO open-drain
// R7: EEPROM clock, else general purpose output
// R8: four axis pins input or open-drain output
// R9: volume-up or crystal-in, readable as input
// R10: volume-down or crystal-out, readable as input
// R11: test strap sampled at reset, high enters test
// R12: bus request tri-stated during host reset
// R13: codec reset low on host reset, software releases
// R14: bit clock pin always an input
// R15: frame sync output in AC97, input otherwise
// R16: interrupt open-drain, level while any pending
// R17: enables from software, defaults after reset
// R18: expanded outputs change on serial falling edge (jbb1 also follows lr_phase; master clock pin toggles each cycle)
module epm_pin_mux (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // configuration
    input wire epm_pkg::epm_link_e link_mode,
    input wire logic eeprom_fitted,
    input wire logic crystal_used,
    input wire epm_pkg::epm_alt_en_s alt_en,
    input wire epm_pkg::epm_gp_ctl_s gp_ctl,
    input wire logic codec_rst_release,
    // core side
    input wire logic ee_clk_core,
    input wire logic ee_dat_drive_low,
    input wire logic xtal_drive,
    input wire logic frame_sync_core,
    input wire logic bus_req_core,
    input wire logic [7:0] irq_pending,
    input wire epm_pkg::epm_audio_s audio,
    // pin inputs
    input wire logic second_serial_in_or_gpio_i,
    input wire logic joy_a_button1_or_second_out_i,
    input wire logic joy_a_button2_or_third_out_i,
    input wire logic joy_b_button1_or_alt_frame_clock_i,
    input wire logic joy_b_button2_or_master_audio_clock_i,
    input wire logic eeprom_data_or_gpio_i,
    input wire logic [3:0] joy_axis_i,
    input wire logic volume_up_or_crystal_in_i,
    input wire logic volume_down_or_crystal_out_i,
    input wire logic serial_bit_clock_pin_i,
    input wire logic serial_frame_sync_pin_i,
    input wire logic test_strap_i,
    // pin outputs
    output epm_pkg::epm_pin_s second_serial_in_or_gpio_o,
    output epm_pkg::epm_pin_s joy_a_button1_or_second_out_o,
    output epm_pkg::epm_pin_s joy_a_button2_or_third_out_o,
    output epm_pkg::epm_pin_s joy_b_button1_or_alt_frame_clock_o,
    output epm_pkg::epm_pin_s joy_b_button2_or_master_audio_clock_o,
    output epm_pkg::epm_pin_s eeprom_data_or_gpio_o,
    output epm_pkg::epm_pin_s eeprom_clock_or_general_output_o,
    output logic [3:0] joy_axis_o,
    output logic [3:0] joy_axis_oe,
    output epm_pkg::epm_pin_s volume_down_or_crystal_out_o,
    output epm_pkg::epm_pin_s serial_frame_sync_pin_o,
    output epm_pkg::epm_pin_s bus_req_n_o,
    output epm_pkg::epm_pin_s host_irq_n_o,
    output logic codec_link_reset_n,
    // values read back by the core
    output logic [3:0] joy_buttons,
    output logic [3:0] joy_axes,
    output logic second_serial_data,
    output logic gpio_in,
    output logic eeprom_data_in,
    output logic volume_up,
    output logic volume_down,
    output logic xtal_in,
    output logic bit_clock,
    output logic frame_sync_in,
    output logic test_mode
);
    typedef struct packed {
        epm_pkg::epm_pin_s sdin2;
        epm_pkg::epm_pin_s jab1;
        epm_pkg::epm_pin_s jab2;
        epm_pkg::epm_pin_s jbb1;
        epm_pkg::epm_pin_s jbb2;
        epm_pkg::epm_pin_s eedat;
        epm_pkg::epm_pin_s eeclk;
        logic [3:0] ax_o;
        logic [3:0] ax_oe;
        epm_pkg::epm_pin_s voldn;
        epm_pkg::epm_pin_s fsync;
        epm_pkg::epm_pin_s req;
        epm_pkg::epm_pin_s irq;
        logic codec_rst_n;
        logic [3:0] buttons;
        logic [3:0] axes;
        logic sdin2_data;
        logic gpin;
        logic eed_in;
        logic vup;
        logic vdn;
        logic xin;
        logic bclk;
        logic fs_in;
        logic bclk_prev;
    } epm_mux_s;

    epm_mux_s mx_reg;
    epm_mux_s mx_next;
    logic non_ac97;
    logic sclk_fall;
    logic mclk_lvl;
    logic lrclk_lvl;

    assign non_ac97 = (link_mode == epm_pkg::EPM_LINK_SERIAL);
    assign sclk_fall = mx_reg.bclk_prev && !serial_bit_clock_pin_i;

    epm_strap u_strap (
        .ref_clk(ref_clk),
        .rst(rst),
        .test_strap(test_strap_i),
        .test_mode(test_mode)
    );

    epm_clkgen u_clkgen (
        .ref_clk(ref_clk),
        .rst(rst),
        .sclk_fall(sclk_fall),
        .mclk_lvl(mclk_lvl),
        .lrclk_lvl(lrclk_lvl)
    );

    always_comb begin
        mx_next = mx_reg;
        mx_next.bclk_prev = serial_bit_clock_pin_i;
        // second serial input or gpio
        mx_next.sdin2.o = gp_ctl.gpio_out;
        mx_next.sdin2.oe = 1'b0;
        if (non_ac97 && alt_en.sdin2_en) begin
            mx_next.sdin2_data = second_serial_in_or_gpio_i; // [R1]
        end else begin
            mx_next.sdin2.oe = gp_ctl.gpio_oe; // [R1]
            mx_next.gpin = second_serial_in_or_gpio_i;
        end
        // joystick buttons, serial data outputs moved on serial falling edge
        mx_next.buttons = {joy_b_button2_or_master_audio_clock_i,
                           joy_b_button1_or_alt_frame_clock_i,
                           joy_a_button2_or_third_out_i,
                           joy_a_button1_or_second_out_i};
        mx_next.jab1.oe = non_ac97 && alt_en.sdo2_en; // [R2]
        mx_next.jab2.oe = non_ac97 && alt_en.sdo3_en; // [R3]
        if (sclk_fall) begin
            mx_next.jab1.o = audio.sdo2_data; // [R2] [R18]
            mx_next.jab2.o = audio.sdo3_data; // [R3] [R18]
        end
        mx_next.jbb1.oe = non_ac97 && alt_en.lrclk_en; // [R4]
        mx_next.jbb1.o = lrclk_lvl ^ audio.lr_phase; // [R4]
        mx_next.jbb2.oe = non_ac97 && alt_en.mclk_en; // [R5]
        mx_next.jbb2.o = mclk_lvl; // [R5]
        // eeprom data: open drain, only ever driven low
        mx_next.eedat.o = 1'b0;
        mx_next.eedat.oe = eeprom_fitted ? ee_dat_drive_low : gp_ctl.eedat_od_low; // [R6]
        mx_next.eed_in = eeprom_data_or_gpio_i; // [R6]
        mx_next.eeclk.oe = 1'b1;
        mx_next.eeclk.o = eeprom_fitted ? ee_clk_core : gp_ctl.eeprom_clock_or_general_output; // [R7]
        // axes: input always readable, open-drain low on demand
        mx_next.axes = joy_axis_i; // [R8]
        mx_next.ax_o = '0;
        mx_next.ax_oe = gp_ctl.axis_od_low; // [R8]
        // volume / crystal pins
        mx_next.vup = volume_up_or_crystal_in_i; // [R9]
        mx_next.xin = crystal_used ? volume_up_or_crystal_in_i : 1'b0; // [R9]
        mx_next.vdn = volume_down_or_crystal_out_i; // [R10]
        mx_next.voldn.o = xtal_drive;
        mx_next.voldn.oe = crystal_used; // [R10]
        // link clock and frame sync
        mx_next.bclk = serial_bit_clock_pin_i; // [R14]
        mx_next.fsync.oe = !non_ac97; // [R15]
        mx_next.fsync.o = frame_sync_core; // [R15]
        mx_next.fs_in = non_ac97 ? serial_frame_sync_pin_i : 1'b0; // [R15]
        // bus request is active low
        mx_next.req.o = !bus_req_core;
        mx_next.req.oe = 1'b1;
        // interrupt: open drain, low while anything pends
        mx_next.irq.o = 1'b0;
        mx_next.irq.oe = |irq_pending; // [R16]
        if (codec_rst_release) begin
            mx_next.codec_rst_n = 1'b1; // [R13]
        end
        if (rst) begin
            mx_next = '0; // [R17]
            mx_next.req.oe = 1'b0; // [R12]
            mx_next.codec_rst_n = 1'b0; // [R13]
            mx_next.eeclk.oe = 1'b1;
            mx_next.bclk_prev = serial_bit_clock_pin_i;
        end
    end

    always_ff @(posedge ref_clk) begin
        mx_reg <= mx_next;
    end

    assign second_serial_in_or_gpio_o = mx_reg.sdin2;
    assign joy_a_button1_or_second_out_o = mx_reg.jab1;
    assign joy_a_button2_or_third_out_o = mx_reg.jab2;
    assign joy_b_button1_or_alt_frame_clock_o = mx_reg.jbb1;
    assign joy_b_button2_or_master_audio_clock_o = mx_reg.jbb2;
    assign eeprom_data_or_gpio_o = mx_reg.eedat;
    assign eeprom_clock_or_general_output_o = mx_reg.eeclk;
    assign joy_axis_o = mx_reg.ax_o;
    assign joy_axis_oe = mx_reg.ax_oe;
    assign volume_down_or_crystal_out_o = mx_reg.voldn;
    assign serial_frame_sync_pin_o = mx_reg.fsync;
    assign bus_req_n_o = mx_reg.req;
    assign host_irq_n_o = mx_reg.irq;
    assign codec_link_reset_n = mx_reg.codec_rst_n;
    assign joy_buttons = mx_reg.buttons;
    assign joy_axes = mx_reg.axes;
    assign second_serial_data = mx_reg.sdin2_data;
    assign gpio_in = mx_reg.gpin;
    assign eeprom_data_in = mx_reg.eed_in;
    assign volume_up = mx_reg.vup;
    assign volume_down = mx_reg.vdn;
    assign xtal_in = mx_reg.xin;
    assign bit_clock = mx_reg.bclk;
    assign frame_sync_in = mx_reg.fs_in;

    second_serial_in_or_gpio_a: assert property (@(posedge ref_clk) disable iff (rst)
        !(non_ac97 && alt_en.sdin2_en) |=> mx_reg.sdin2.oe == $past(gp_ctl.gpio_oe))
        else $error("second input pin not in gpio role"); // [R1]
    sdo2_drive_a: assert property (@(posedge ref_clk) disable iff (rst)
        mx_reg.jab1.oe |-> $past(non_ac97 && alt_en.sdo2_en))
        else $error("second out driven without enable"); // [R2]
    sdo3_drive_a: assert property (@(posedge ref_clk) disable iff (rst)
        mx_reg.jab2.oe |-> $past(non_ac97 && alt_en.sdo3_en))
        else $error("third out driven without enable"); // [R3]
    sdo_edge_a: assert property (@(posedge ref_clk) disable iff (rst)
        $changed(mx_reg.jab1.o) |-> $past(sclk_fall))
        else $error("second out moved off falling edge"); // [R18]
    eedat_od_a: assert property (@(posedge ref_clk)
        mx_reg.eedat.o == 1'b0)
        else $error("eeprom data driven high"); // [R6]
    eeclk_sel_a: assert property (@(posedge ref_clk) disable iff (rst)
        !$past(eeprom_fitted) && !$past(rst) |-> mx_reg.eeclk.o == $past(gp_ctl.eeprom_clock_or_general_output))
        else $error("eeprom clock pin not general output"); // [R7]
    req_hiz_a: assert property (@(posedge ref_clk)
        $past(rst) |-> !mx_reg.req.oe)
        else $error("bus request driven during reset"); // [R12]
    codec_rst_a: assert property (@(posedge ref_clk)
        $past(rst) |-> !codec_link_reset_n ##1 (!codec_link_reset_n || $past(codec_rst_release)))
        else $error("codec reset released without software"); // [R13]
    irq_level_a: assert property (@(posedge ref_clk) disable iff (rst)
        (|irq_pending) [*2] |-> mx_reg.irq.oe && !mx_reg.irq.o)
        else $error("interrupt not asserted while pending"); // [R16]
    fsync_dir_a: assert property (@(posedge ref_clk) disable iff (rst)
        !$past(rst) |-> mx_reg.fsync.oe == ($past(link_mode) == epm_pkg::EPM_LINK_AC97))
        else $error("frame sync direction wrong"); // [R15]
    reset_dflt_a: assert property (@(posedge ref_clk)
        $past(rst) |-> !mx_reg.jab1.oe && !mx_reg.jbb2.oe && !mx_reg.sdin2.oe)
        else $error("shared pin not default after reset"); // [R17]

    sdo2_live_c: cover property (@(posedge ref_clk) mx_reg.jab1.oe && sclk_fall);
    mclk_live_c: cover property (@(posedge ref_clk) mx_reg.jbb2.oe);
    codec_rel_c: cover property (@(posedge ref_clk) $rose(codec_link_reset_n));
    irq_live_c: cover property (@(posedge ref_clk) mx_reg.irq.oe);
endmodule : epm_pin_mux

// ### dv/epm_far_side.sv
`timescale 1ns/100ps
module epm_far_side (
    // clock and board stimulus
    input wire logic ref_clk,
    input wire logic sclk_run,
    input wire logic ee_pull_low,
    input wire logic [3:0] axis_lvl,
    // pins driven by the block
    input wire epm_pkg::epm_pin_s eedat_pin,
    input wire logic [3:0] axis_o,
    input wire logic [3:0] axis_oe,
    // resolved pin levels
    output logic sclk,
    output logic eedat,
    output logic [3:0] axis
);
    logic [1:0] div_reg = 2'h0;

    // codec serial clock runs only within frames and stands low otherwise
    always @(posedge ref_clk) begin
        div_reg <= sclk_run ? div_reg + 2'h1 : 2'h0;
    end
    assign sclk = div_reg[1];
    // pull-up on the data line; the memory or the block may pull it low
    assign eedat = ~((eedat_pin.oe & ~eedat_pin.o) | ee_pull_low);
    assign axis = (axis_oe & axis_o) | (~axis_oe & axis_lvl);
endmodule : epm_far_side

// ### dv/external_pin_function_mux_test.sv
`timescale 1ns/100ps
module external_pin_function_mux_test;
    typedef struct {string n; logic [7:0] e; logic [7:0] m;} epm_note_s;
    epm_note_s q[$];
    int err_count = 0, check_count = 0;
    logic ref_clk = 1'b0, rst = 1'b1, eef = 1'b0, xu = 1'b0, crr = 1'b0, eck = 1'b0;
    logic edl = 1'b0, xd = 1'b0, fsc = 1'b0, brc = 1'b0, sclk_run = 1'b0;
    logic [7:0] irqp = 8'h00;
    logic [15:0] bv = 16'h2000;
    logic [31:0] seed = 32'h0000_da34;
    epm_pkg::epm_link_e lm = epm_pkg::EPM_LINK_SERIAL;
    epm_pkg::epm_alt_en_s alt = '0;
    epm_pkg::epm_gp_ctl_s gpc = '0;
    epm_pkg::epm_audio_s aud = '0;
    epm_pkg::epm_pin_s s2, ja1, ja2, jb1, jb2, eed, eec, vd, fs, br, irq;
    logic i_s2, i_ja1, i_ja2, i_jb1, i_jb2, i_eed, i_vu, i_vd, i_bc, i_fs, i_ts;
    logic crst, ser2, gpin, eein, volup, voldn, xtal, bclk, fsin, tm;
    logic [3:0] i_ax, axo, axoe, btn, axes;

    initial forever #50 ref_clk = ~ref_clk;

    // two-way pins: the block wins while it drives, else the board level
    assign i_s2 = s2.oe ? s2.o : bv[0];
    assign i_ja1 = ja1.oe ? ja1.o : bv[1];
    assign i_ja2 = ja2.oe ? ja2.o : bv[2];
    assign i_jb1 = jb1.oe ? jb1.o : bv[3];
    assign i_jb2 = jb2.oe ? jb2.o : bv[4];
    assign i_vu = bv[10];
    assign i_vd = vd.oe ? vd.o : bv[11];
    assign i_fs = fs.oe ? fs.o : bv[12];
    assign i_ts = bv[13];

    epm_pin_mux dut (
        .ref_clk(ref_clk), .rst(rst), .link_mode(lm), .eeprom_fitted(eef), .crystal_used(xu),
        .alt_en(alt), .gp_ctl(gpc), .codec_rst_release(crr), .ee_clk_core(eck),
        .ee_dat_drive_low(edl), .xtal_drive(xd), .frame_sync_core(fsc), .bus_req_core(brc),
        .irq_pending(irqp), .audio(aud), .second_serial_in_or_gpio_i(i_s2),
        .joy_a_button1_or_second_out_i(i_ja1), .joy_a_button2_or_third_out_i(i_ja2),
        .joy_b_button1_or_alt_frame_clock_i(i_jb1),
        .joy_b_button2_or_master_audio_clock_i(i_jb2),
        .eeprom_data_or_gpio_i(i_eed), .joy_axis_i(i_ax), .volume_up_or_crystal_in_i(i_vu),
        .volume_down_or_crystal_out_i(i_vd), .serial_bit_clock_pin_i(i_bc),
        .serial_frame_sync_pin_i(i_fs), .test_strap_i(i_ts),
        .second_serial_in_or_gpio_o(s2), .joy_a_button1_or_second_out_o(ja1),
        .joy_a_button2_or_third_out_o(ja2), .joy_b_button1_or_alt_frame_clock_o(jb1),
        .joy_b_button2_or_master_audio_clock_o(jb2), .eeprom_data_or_gpio_o(eed),
        .eeprom_clock_or_general_output_o(eec), .joy_axis_o(axo), .joy_axis_oe(axoe),
        .volume_down_or_crystal_out_o(vd), .serial_frame_sync_pin_o(fs), .bus_req_n_o(br),
        .host_irq_n_o(irq), .codec_link_reset_n(crst), .joy_buttons(btn), .joy_axes(axes),
        .second_serial_data(ser2), .gpio_in(gpin), .eeprom_data_in(eein), .volume_up(volup),
        .volume_down(voldn), .xtal_in(xtal), .bit_clock(bclk), .frame_sync_in(fsin),
        .test_mode(tm)
    );

    epm_far_side board (
        .ref_clk(ref_clk), .sclk_run(sclk_run), .ee_pull_low(bv[5]), .axis_lvl(bv[9:6]),
        .eedat_pin(eed), .axis_o(axo), .axis_oe(axoe), .sclk(i_bc), .eedat(i_eed), .axis(i_ax)
    );

    function automatic logic [7:0] obs(string n);
        case (n)
            "s2": return {6'h0, s2};
            "ja1": return {6'h0, ja1};
            "ja2": return {6'h0, ja2};
            "jb1": return {6'h0, jb1};
            "jb2": return {6'h0, jb2};
            "eed": return {6'h0, eed};
            "eec": return {6'h0, eec};
            "vd": return {6'h0, vd};
            "fs": return {6'h0, fs};
            "br": return {6'h0, br};
            "irq": return {6'h0, irq};
            "axo": return {4'h0, axo};
            "axoe": return {4'h0, axoe};
            "btn": return {4'h0, btn};
            "axes": return {4'h0, axes};
            "ser2": return {7'h0, ser2};
            default: return {tm, fsin, bclk, xtal, voldn, volup, eein, gpin};
        endcase
    endfunction : obs

    function automatic logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic note(string n, logic [7:0] e, logic [7:0] m = 8'hff);
        q.push_back('{n, e, m});
    endtask : note

    task automatic settle(int k);
        repeat (k) @(posedge ref_clk);
    endtask : settle

    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : close_out

    task automatic drain(string t);
        for (int i = 0; i < 4 && q.size() > 0; i++) @(posedge ref_clk);
        if (q.size() > 0) begin
            err_count++;
            close_out();
        end else
            $display("test %s done", t);
    endtask : drain

    // all enables but the eeprom clock's off while reset is applied; single-bit read-backs other than ser2 sit in the "rb" byte
    task automatic defaults(logic strap);
        string k[$] = '{"s2", "ja1", "ja2", "jb1", "jb2", "eed", "vd", "fs", "irq"};
        foreach (k[i]) note(k[i], 8'h00, 8'h01);
        note("eec", 8'h01);
        note("br", 8'h00, 8'h01);
        note("crst", 8'h00, 8'h80);
        note("rb", {strap, 7'h0}, 8'h80);
        note("axo", 8'h00);
        note("axoe", 8'h00);
    endtask : defaults

    initial begin : watch
        epm_note_s t;
        forever begin
            @(negedge ref_clk);
            while (q.size() > 0) begin
                t = q.pop_front();
                check_count++;
                if (t.n == "crst" && {7'h0, crst} !== t.e[7:7]) begin
                    err_count++;
                    $display("BAD codec_reset expected %h seen %h", t.e[7], crst);
                end else if (t.n != "crst" && (obs(t.n) & t.m) !== t.e) begin
                    err_count++;
                    $display("BAD %s expected %h seen %h", t.n, t.e, obs(t.n) & t.m);
                end
            end
        end
    end

    initial begin
        settle(4000);
        err_count++;
        close_out();
    end

    initial begin
        settle(6);
        defaults(1'b1);
        drain("reset");
        rst <= 1'b0;
        seed = lfsr(seed);
        alt <= '1;
        sclk_run <= 1'b1;
        aud <= seed[2:0];
        bv[0] <= seed[3];
        settle(14);
        note("ja1", {6'h0, aud.sdo2_data, 1'b1});
        note("ja2", {6'h0, aud.sdo3_data, 1'b1});
        note("jb1", 8'h01, 8'h01);
        note("jb2", 8'h01, 8'h01);
        note("s2", 8'h00, 8'h01);
        note("ser2", {7'h0, bv[0]});
        drain("serial alternates");
        sclk_run <= 1'b0;
        settle(4);
        aud <= ~aud;
        settle(6);
        note("ja1", {6'h0, ~aud.sdo2_data, 1'b1});
        drain("held data");
        sclk_run <= 1'b1;
        settle(12);
        note("ja1", {6'h0, aud.sdo2_data, 1'b1});
        drain("data after fall");
        seed = lfsr(seed);
        lm <= epm_pkg::EPM_LINK_AC97;
        sclk_run <= 1'b0;
        fsc <= seed[0];
        bv[4:1] <= seed[4:1];
        settle(6);
        for (int i = 0; i < 5; i++) note(i == 4 ? "s2" : "ja1", 8'h00, 8'h01);
        note("ja2", 8'h00, 8'h01);
        note("jb1", 8'h00, 8'h01);
        note("jb2", 8'h00, 8'h01);
        note("fs", {6'h0, fsc, 1'b1});
        note("btn", {4'h0, bv[4:1]});
        note("rb", 8'h00, 8'h20);
        drain("ac97 refusals");
        seed = lfsr(seed);
        lm <= epm_pkg::EPM_LINK_SERIAL;
        alt <= '0;
        gpc.gpio_oe <= 1'b1;
        gpc.gpio_out <= seed[0];
        bv[12] <= seed[1];
        settle(6);
        note("s2", {6'h0, gpc.gpio_out, 1'b1});
        note("fs", 8'h00, 8'h01);
        note("rb", {1'b0, bv[12], 6'h0}, 8'h40);
        drain("serial gpio");
        gpc.gpio_oe <= 1'b0;
        settle(6);
        note("rb", {7'h0, bv[0]}, 8'h01);
        drain("gpio input");
        for (int i = 0; i < 4; i++) begin
            logic d;
            d = i[1] ~^ i[0];
            eef <= i[1];
            edl <= i[0];
            gpc.eedat_od_low <= ~i[0];
            eck <= i[0];
            gpc.eeprom_clock_or_general_output <= ~i[0];
            settle(6);
            note("eed", {7'h0, d}, {6'h0, d, 1'b1});
            note("eec", {6'h0, d, 1'b1});
            note("rb", {6'h0, ~d, 1'b0}, 8'h02);
            drain("eeprom");
        end
        for (int j = 0; j < 3; j++) begin
            seed = lfsr(seed);
            gpc.axis_od_low <= seed[3:0];
            bv[11:6] <= seed[9:4];
            xu <= j[0];
            xd <= seed[10];
            irqp <= (j == 0) ? 8'h00 : (j == 1) ? 8'h80 : seed[18:11];
            settle(6);
            note("axoe", {4'h0, gpc.axis_od_low});
            note("axo", 8'h00, {4'h0, gpc.axis_od_low});
            note("axes", {4'h0, bv[9:6] & ~gpc.axis_od_low});
            if (xu) begin
                note("vd", {6'h0, xd, 1'b1});
                note("rb", {3'h0, bv[10], xd, bv[10], 2'h0}, 8'h1c);
            end else begin
                note("vd", 8'h00, 8'h01);
                note("rb", {3'h0, 1'b0, bv[11], bv[10], 2'h0}, 8'h1c);
            end
            note("irq", {7'h0, |irqp}, {6'h0, |irqp, 1'b1});
            drain("axes volume interrupt");
        end
        brc <= 1'b1;
        crr <= 1'b1;
        alt <= '1;
        @(posedge ref_clk);
        crr <= 1'b0;
        settle(6);
        note("br", 8'h01);
        note("crst", 8'h80);
        drain("request and codec release");
        rst <= 1'b1;
        bv[13] <= 1'b0;
        settle(3);
        defaults(1'b0);
        drain("second reset");
        rst <= 1'b0;
        settle(3);
        note("crst", 8'h00);
        drain("codec reset held");
        close_out();
    end
endmodule : external_pin_function_mux_test
